// ===== idpu_defs.svh
// Constants for the indirect data pointer unit
`ifndef IDPU_DEFS_SVH
`define IDPU_DEFS_SVH

// Widths, memory depth and pointer count
`define IDPU_ADDR_W        12
`define IDPU_DATA_W        8
`define IDPU_HI_W          4
`define IDPU_MEM_DEPTH     4096
`define IDPU_NUM_PTR       3

// Pointer two slice
`define IDPU_OFS_PTR2_LO   12'hFD9
`define IDPU_OFS_PTR2_HI   12'hFDA
`define IDPU_OFS_PTR2_OFFSET_W_PORT    12'hFDB
`define IDPU_OFS_PTR2_PRE_INCREMENT_PORT_PORT   12'hFDC
`define IDPU_OFS_PTR2_POST_DECREMENT_PORT_PORT  12'hFDD
`define IDPU_OFS_PTR2_POST_INCREMENT_PORT_PORT  12'hFDE
`define IDPU_OFS_PLAIN2    12'hFDF
// Bank select
`define IDPU_OFS_BANK      12'hFE0
// Pointer one slice
`define IDPU_OFS_PTR1_LO   12'hFE1
`define IDPU_OFS_PTR1_HI   12'hFE2
`define IDPU_OFS_PTR1_OFFSET_W_PORT    12'hFE3
`define IDPU_OFS_PTR1_PRE_INCREMENT_PORT_PORT   12'hFE4
`define IDPU_OFS_PTR1_POST_DECREMENT_PORT_PORT  12'hFE5
`define IDPU_OFS_PTR1_POST_INCREMENT_PORT_PORT  12'hFE6
`define IDPU_OFS_PLAIN1    12'hFE7
// Working accumulator
`define IDPU_OFS_WACC      12'hFE8
// Pointer zero slice
`define IDPU_OFS_PTR0_LO   12'hFE9
`define IDPU_OFS_PTR0_HI   12'hFEA
`define IDPU_OFS_PTR0_OFFSET_W_PORT    12'hFEB
`define IDPU_OFS_PTR0_PRE_INCREMENT_PORT_PORT   12'hFEC
`define IDPU_OFS_PTR0_POST_DECREMENT_PORT_PORT  12'hFED
`define IDPU_OFS_POSTINC0  12'hFEE
`define IDPU_OFS_PLAIN0    12'hFEF

// Reset values
`define IDPU_PTR_HI_RST    4'h0
`define IDPU_PTR_LO_RST    8'h00
`define IDPU_WACC_RST      8'h00
`define IDPU_BANK_RST      4'h0
`define IDPU_RDATA_RST     8'h00

`endif

// ===== idpu_pkg.sv
// Types for the indirect data pointer unit
`include "idpu_defs.svh"

package idpu_pkg;

  // Kind of location that an address selects
  typedef enum logic [3:0] {
    ACC_MEM,
    ACC_PLAIN,
    ACC_POST_INCREMENT_PORT,
    ACC_POST_DECREMENT_PORT,
    ACC_PRE_INCREMENT_PORT,
    ACC_OFFSET_BY_ACCUMULATOR_PORT,
    ACC_PTR_LO,
    ACC_PTR_HI,
    ACC_WACC,
    ACC_BANK
  } idpu_acc_t;

  // Decoded address: kind and pointer number
  typedef struct packed {
    idpu_acc_t  kind;
    logic [1:0] sel;
  } idpu_dec_t;

  // One register port request
  typedef struct packed {
    logic                    wr;
    logic                    rd;
    logic [`IDPU_ADDR_W-1:0] addr;
    logic [`IDPU_DATA_W-1:0] wdata;
  } idpu_req_t;

  // All state of the unit
  typedef struct packed {
    logic [`IDPU_NUM_PTR-1:0][`IDPU_ADDR_W-1:0] ptr;
    logic [`IDPU_DATA_W-1:0]                    wacc;
    logic [`IDPU_HI_W-1:0]                      bank;
  } idpu_state_t;

endpackage : idpu_pkg

// ===== idpu_data_ram.sv
// Data memory with registered read data and a bypass input
`timescale 1ns/1ps
`default_nettype none
`include "idpu_defs.svh"

module idpu_data_ram
  import idpu_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    we_i,
  input  wire logic                    re_i,
  input  wire logic [`IDPU_ADDR_W-1:0] addr_i,
  input  wire logic [`IDPU_DATA_W-1:0] wdata_i,
  input  wire logic                    byp_i,
  input  wire logic [`IDPU_DATA_W-1:0] byp_data_i,
  output var  logic [`IDPU_DATA_W-1:0] rdata_o
);

  // Storage array, no reset
  logic [`IDPU_DATA_W-1:0] mem [`IDPU_MEM_DEPTH];
  logic [`IDPU_DATA_W-1:0] rdata_reg;   // Read data register

  // Write port
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // Read register: memory byte or bypassed register value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= `IDPU_RDATA_RST;
    end else if (re_i) begin
      rdata_reg <= byp_i ? byp_data_i : mem[addr_i];
    end
  end

  assign rdata_o = rdata_reg;

endmodule : idpu_data_ram
`default_nettype wire

// ===== idpu_indirect_unit.sv
// Indirect data pointer unit: pointers, operand ports, data memory
`timescale 1ns/1ps
`default_nettype none
`include "idpu_defs.svh"

// Functional notes
// RULE1 - Indirect ports reach memory at pointer address
// RULE2 - Offset port uses pointer plus accumulator
// RULE3 - Indirect ports hold no storage themselves
// RULE4 - High byte keeps four bits, reset zero
// RULE5 - Plain, post and pre step updates
module idpu_indirect_unit
  import idpu_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [`IDPU_ADDR_W-1:0] addr_i,
  input  wire logic [`IDPU_DATA_W-1:0] wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output var  logic [`IDPU_DATA_W-1:0] rdata_o
);

  // Step constant for pointer arithmetic
  localparam logic [`IDPU_ADDR_W-1:0] PTR_ONE = 12'h001;

  // Register state and its next value
  idpu_state_t st_reg;     // Registered state
  idpu_state_t st_next;    // Next state

  // Request and decode
  idpu_req_t   req;        // Bundled request
  idpu_dec_t   dec;        // Decoded address
  logic        active;     // Any strobe this cycle
  logic        is_ind;     // Address is an indirect port

  // Pointer view and derived values
  logic [`IDPU_ADDR_W-1:0] sel_ptr;   // Pointer chosen by decode
  logic [`IDPU_ADDR_W-1:0] eff_addr;  // Memory address of access

  // Per pointer stepped values
  logic [`IDPU_NUM_PTR-1:0]                    ptr_hit;
  logic [`IDPU_NUM_PTR-1:0][`IDPU_ADDR_W-1:0]  ptr_step;

  // Memory port signals
  logic                    mem_we;    // Memory write enable
  logic [`IDPU_ADDR_W-1:0] mem_addr;  // Memory address
  logic                    byp;       // Read from a register
  logic [`IDPU_DATA_W-1:0] byp_data;  // Register read value

  // Decode an address into kind and pointer number
  function automatic idpu_dec_t decode_addr(
    input logic [`IDPU_ADDR_W-1:0] a
  );
    idpu_dec_t d;
    d.kind = ACC_MEM;
    d.sel  = 2'h0;
    case (a)
      // Pointer zero group
      `IDPU_OFS_PLAIN0: begin
        d.kind = ACC_PLAIN;
        d.sel  = 2'h0;
      end
      `IDPU_OFS_POSTINC0: begin
        d.kind = ACC_POST_INCREMENT_PORT;
        d.sel  = 2'h0;
      end
      `IDPU_OFS_PTR0_POST_DECREMENT_PORT_PORT: begin
        d.kind = ACC_POST_DECREMENT_PORT;
        d.sel  = 2'h0;
      end
      `IDPU_OFS_PTR0_PRE_INCREMENT_PORT_PORT: begin
        d.kind = ACC_PRE_INCREMENT_PORT;
        d.sel  = 2'h0;
      end
      `IDPU_OFS_PTR0_OFFSET_W_PORT: begin
        d.kind = ACC_OFFSET_BY_ACCUMULATOR_PORT;
        d.sel  = 2'h0;
      end
      `IDPU_OFS_PTR0_HI: begin
        d.kind = ACC_PTR_HI;
        d.sel  = 2'h0;
      end
      `IDPU_OFS_PTR0_LO: begin
        d.kind = ACC_PTR_LO;
        d.sel  = 2'h0;
      end
      // Accumulator
      `IDPU_OFS_WACC: begin
        d.kind = ACC_WACC;
      end
      // Pointer one group
      `IDPU_OFS_PLAIN1: begin
        d.kind = ACC_PLAIN;
        d.sel  = 2'h1;
      end
      `IDPU_OFS_PTR1_POST_INCREMENT_PORT_PORT: begin
        d.kind = ACC_POST_INCREMENT_PORT;
        d.sel  = 2'h1;
      end
      `IDPU_OFS_PTR1_POST_DECREMENT_PORT_PORT: begin
        d.kind = ACC_POST_DECREMENT_PORT;
        d.sel  = 2'h1;
      end
      `IDPU_OFS_PTR1_PRE_INCREMENT_PORT_PORT: begin
        d.kind = ACC_PRE_INCREMENT_PORT;
        d.sel  = 2'h1;
      end
      `IDPU_OFS_PTR1_OFFSET_W_PORT: begin
        d.kind = ACC_OFFSET_BY_ACCUMULATOR_PORT;
        d.sel  = 2'h1;
      end
      `IDPU_OFS_PTR1_HI: begin
        d.kind = ACC_PTR_HI;
        d.sel  = 2'h1;
      end
      `IDPU_OFS_PTR1_LO: begin
        d.kind = ACC_PTR_LO;
        d.sel  = 2'h1;
      end
      // Bank select
      `IDPU_OFS_BANK: begin
        d.kind = ACC_BANK;
      end
      // Pointer two group
      `IDPU_OFS_PLAIN2: begin
        d.kind = ACC_PLAIN;
        d.sel  = 2'h2;
      end
      `IDPU_OFS_PTR2_POST_INCREMENT_PORT_PORT: begin
        d.kind = ACC_POST_INCREMENT_PORT;
        d.sel  = 2'h2;
      end
      `IDPU_OFS_PTR2_POST_DECREMENT_PORT_PORT: begin
        d.kind = ACC_POST_DECREMENT_PORT;
        d.sel  = 2'h2;
      end
      `IDPU_OFS_PTR2_PRE_INCREMENT_PORT_PORT: begin
        d.kind = ACC_PRE_INCREMENT_PORT;
        d.sel  = 2'h2;
      end
      `IDPU_OFS_PTR2_OFFSET_W_PORT: begin
        d.kind = ACC_OFFSET_BY_ACCUMULATOR_PORT;
        d.sel  = 2'h2;
      end
      `IDPU_OFS_PTR2_HI: begin
        d.kind = ACC_PTR_HI;
        d.sel  = 2'h2;
      end
      `IDPU_OFS_PTR2_LO: begin
        d.kind = ACC_PTR_LO;
        d.sel  = 2'h2;
      end
      // Everything else is plain data memory
      default: begin
        d.kind = ACC_MEM;
        d.sel  = 2'h0;
      end
    endcase
    return d;
  endfunction : decode_addr

  // True for the five redirecting port kinds
  function automatic logic is_indirect(input idpu_acc_t k);
    logic r;
    r = 1'b0;
    case (k)
      ACC_PLAIN,
      ACC_POST_INCREMENT_PORT,
      ACC_POST_DECREMENT_PORT,
      ACC_PRE_INCREMENT_PORT,
      ACC_OFFSET_BY_ACCUMULATOR_PORT: r = 1'b1;
      default:   r = 1'b0;
    endcase
    return r;
  endfunction : is_indirect

  // Memory address used by one indirect access
  function automatic logic [`IDPU_ADDR_W-1:0] access_addr(
    input idpu_acc_t               k,
    input logic [`IDPU_ADDR_W-1:0] p,
    input logic [`IDPU_DATA_W-1:0] w
  );
    logic [`IDPU_ADDR_W-1:0] r;
    r = p;
    case (k)
      ACC_PRE_INCREMENT_PORT: r = p + PTR_ONE;                      // RULE5
      ACC_OFFSET_BY_ACCUMULATOR_PORT:  r = p + {{`IDPU_HI_W{1'b0}}, w};      // RULE2
      default:    r = p;                                // RULE1
    endcase
    return r;
  endfunction : access_addr

  // Pointer value after one indirect access
  function automatic logic [`IDPU_ADDR_W-1:0] stepped_ptr(
    input idpu_acc_t               k,
    input logic [`IDPU_ADDR_W-1:0] p
  );
    logic [`IDPU_ADDR_W-1:0] r;
    r = p;
    case (k)
      ACC_POST_INCREMENT_PORT: r = p + PTR_ONE;   // RULE5
      ACC_PRE_INCREMENT_PORT:  r = p + PTR_ONE;   // RULE5
      ACC_POST_DECREMENT_PORT: r = p - PTR_ONE;   // RULE5
      default:     r = p;             // RULE2
    endcase
    return r;
  endfunction : stepped_ptr

  // Bundle the port request
  always_comb begin
    req.wr    = wr_i;
    req.rd    = rd_i;
    req.addr  = addr_i;
    req.wdata = wdata_i;
  end

  // Decode and pointer selection
  always_comb begin
    dec      = decode_addr(req.addr);
    active   = req.wr | req.rd;
    is_ind   = is_indirect(dec.kind);
    sel_ptr  = st_reg.ptr[0];
    if (dec.sel == 2'h1) begin
      sel_ptr = st_reg.ptr[1];
    end else if (dec.sel == 2'h2) begin
      sel_ptr = st_reg.ptr[2];
    end
    eff_addr = access_addr(dec.kind, sel_ptr, st_reg.wacc);
  end

  // Per pointer hit and stepped value
  genvar gi;
  generate
    for (gi = 0; gi < `IDPU_NUM_PTR; gi++) begin : g_ptr
      // This pointer is the one being used
      assign ptr_hit[gi]  = active && is_ind &&
                            (dec.sel == 2'(gi));
      // Its value after the access
      assign ptr_step[gi] = stepped_ptr(dec.kind,
                                        st_reg.ptr[gi]);
    end
  endgenerate

  // Next state: pointer steps and register writes
  always_comb begin
    st_next = st_reg;
    // Step the pointer that an indirect access used
    for (int i = 0; i < `IDPU_NUM_PTR; i++) begin
      if (ptr_hit[i]) begin
        st_next.ptr[i] = ptr_step[i];   // RULE5
      end
    end
    // Direct writes to the pointer and core registers
    if (req.wr) begin
      case (dec.kind)
        ACC_PTR_LO: begin
          st_next.ptr[dec.sel][7:0] = req.wdata;
        end
        ACC_PTR_HI: begin
          // Only the low nibble is kept
          st_next.ptr[dec.sel][11:8] =
            req.wdata[`IDPU_HI_W-1:0];   // RULE4
        end
        ACC_WACC: begin
          st_next.wacc = req.wdata;
        end
        ACC_BANK: begin
          st_next.bank = req.wdata[`IDPU_HI_W-1:0];
        end
        default: begin
          // Memory and indirect writes change no register beyond the pointer step above
          st_next.wacc = st_reg.wacc;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `IDPU_NUM_PTR; i++) begin
        st_reg.ptr[i][11:8] <= `IDPU_PTR_HI_RST;   // RULE4
        st_reg.ptr[i][7:0]  <= `IDPU_PTR_LO_RST;
      end
      st_reg.wacc <= `IDPU_WACC_RST;
      st_reg.bank <= `IDPU_BANK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Route the access to memory or to a register
  always_comb begin
    mem_addr = req.addr;
    mem_we   = 1'b0;
    byp      = 1'b0;
    byp_data = 8'h00;
    case (dec.kind)
      ACC_MEM: begin
        mem_we = req.wr;
      end
      ACC_PLAIN,
      ACC_POST_INCREMENT_PORT,
      ACC_POST_DECREMENT_PORT,
      ACC_PRE_INCREMENT_PORT,
      ACC_OFFSET_BY_ACCUMULATOR_PORT: begin
        // No cell of its own: redirect to memory
        mem_addr = eff_addr;   // RULE3
        mem_we   = req.wr;     // RULE1
      end
      ACC_PTR_LO: begin
        byp      = 1'b1;
        byp_data = sel_ptr[7:0];
      end
      ACC_PTR_HI: begin
        // Unimplemented upper nibble reads zero
        byp      = 1'b1;
        byp_data = {4'h0, sel_ptr[11:8]};   // RULE4
      end
      ACC_WACC: begin
        byp      = 1'b1;
        byp_data = st_reg.wacc;
      end
      ACC_BANK: begin
        byp      = 1'b1;
        byp_data = {4'h0, st_reg.bank};
      end
      default: begin
        byp = 1'b0;
      end
    endcase
  end

  // Data memory; its read register drives the read data
  idpu_data_ram u_ram (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .we_i       (mem_we),
    .re_i       (req.rd),
    .addr_i     (mem_addr),
    .wdata_i    (req.wdata),
    .byp_i      (byp),
    .byp_data_i (byp_data),
    .rdata_o    (rdata_o)
  );

endmodule : idpu_indirect_unit
`default_nettype wire

// ===== idpu_indirect_unit_assertions.sv
// Port checker for the indirect data pointer unit
`timescale 1ns/1ps
`default_nettype none
`include "idpu_defs.svh"

module idpu_checker
  import idpu_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic [`IDPU_ADDR_W-1:0] addr_i,
  input wire logic [`IDPU_DATA_W-1:0] wdata_i,
  input wire logic                    wr_i,
  input wire logic                    rd_i,
  input wire logic [`IDPU_DATA_W-1:0] rdata_o
);
  // One clock domain, reset disables all
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Write one location, read one (often the same) next cycle, masked data back
  property wr_rd(aw, ar, m);
    (wr_i && addr_i == aw) ##1 (rd_i && addr_i == ar)
      |=> rdata_o == ($past(wdata_i, 2) & m);
  endproperty

  AST_PLAIN0_BACK: assert property (wr_rd(12'hFEF, 12'hFEF, 8'hFF))
    else $error("plain port read back differs");
  AST_PLAIN2_BACK: assert property (wr_rd(12'hFDF, 12'hFDF, 8'hFF))
    else $error("pointer two plain read back differs");
  AST_OFFSET_BACK: assert property (wr_rd(12'hFEB, 12'hFEB, 8'hFF))
    else $error("offset port moved its target");
  AST_HIGH0_MASK: assert property (wr_rd(12'hFEA, 12'hFEA, 8'h0F))
    else $error("pointer zero high byte not four bits");
  AST_HIGH1_MASK: assert property (wr_rd(12'hFE2, 12'hFE2, 8'h0F))
    else $error("pointer one high byte not four bits");
  AST_HIGH2_MASK: assert property (wr_rd(12'hFDA, 12'hFDA, 8'h0F))
    else $error("pointer two high byte not four bits");
  AST_PRE_INCREMENT_PORT_PLAIN: assert property (wr_rd(12'hFEC, 12'hFEF, 8'hFF))
    else $error("pre-increment write not at new pointer");
  AST_POST_DECREMENT_PORT_PRE_INCREMENT_PORT: assert property (wr_rd(12'hFED, 12'hFEC, 8'hFF))
    else $error("post-decrement step wrong");
  AST_RDATA_HOLD: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");

  // Main scenarios seen
  COV_PLAIN: cover property (wr_i && addr_i == 12'hFEF ##1 rd_i);
  COV_OFFSET: cover property (rd_i && addr_i == 12'hFDB);
  COV_POST_INCREMENT_PORT: cover property (rd_i && addr_i == 12'hFE6);
endmodule : idpu_checker

bind idpu_indirect_unit idpu_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
`default_nettype wire

// ===== indirect_data_pointer_unit_tb_top.sv
// Self-checking bench for the indirect data pointer unit
`timescale 1ns/1ps
`default_nettype none
`include "idpu_defs.svh"

`define CHK(a, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("BAD rdata_o at %h exp %h got %h", a, e, g); end end

module indirect_data_pointer_unit_tb_top;
  import idpu_pkg::*;
  logic        clk_i   = 1'b0;  // Core clock
  logic        rst_i   = 1'b1;  // Synchronous reset
  logic [11:0] addr_i  = 12'h000;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [7:0]  rdata_o;         // Read data
  int          failures = 0;    // Mismatch count
  int          n_tests  = 0;    // Comparison count
  logic [11:0] hi_a [4] = '{12'hFEA, 12'hFE2, 12'hFDA, 12'hFE0};

  idpu_indirect_unit uut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));

  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // One bus cycle right after an edge
  task op(input logic w, input logic r, input logic [11:0] a,
          input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
  endtask : op

  // Write strobe, may be followed at once by the next cycle
  task wr(input logic [11:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask : wr

  // Read, then compare data in the following cycle
  task rd(input logic [11:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b0, 12'h000, 8'h00);
    #1;
    `CHK(a, e, rdata_o)
  endtask : rd

  // High bytes and bank cleared at reset, four bits kept
  task t_high;
    foreach (hi_a[i]) begin
      rd(hi_a[i], 8'h00);
      wr(hi_a[i], 8'hFF);
      rd(hi_a[i], 8'h0F);
      wr(hi_a[i], 8'h00);
    end
  endtask : t_high

  // Plain port reaches memory, pointer untouched
  task t_plain;
    wr(12'hFE9, 8'h34);
    wr(12'hFEA, 8'h01);
    wr(12'h134, 8'hA5);
    rd(12'hFEF, 8'hA5);
    wr(12'hFEF, 8'h5A);
    rd(12'hFEF, 8'h5A);
    rd(12'h134, 8'h5A);
    rd(12'hFE9, 8'h34);
  endtask : t_plain

  // Post and pre steps of pointer zero
  task t_steps;
    wr(12'h134, 8'h11);
    wr(12'h135, 8'h22);
    wr(12'h136, 8'h33);
    rd(12'hFEE, 8'h11);
    rd(12'hFE9, 8'h35);
    rd(12'hFEC, 8'h33);
    rd(12'hFED, 8'h33);
    rd(12'hFEF, 8'h22);
    wr(12'hFED, 8'h44);
    rd(12'hFEC, 8'h44);
    wr(12'hFEC, 8'h55);
    rd(12'hFEF, 8'h55);
  endtask : t_steps

  // Carry, borrow and wrap across the pointer pair
  task t_carry;
    wr(12'hFE1, 8'hFF);
    wr(12'h0FF, 8'h66);
    wr(12'h100, 8'h77);
    rd(12'hFE6, 8'h66);
    rd(12'hFE2, 8'h01);
    rd(12'hFE1, 8'h00);
    rd(12'hFE5, 8'h77);
    rd(12'hFE2, 8'h00);
    rd(12'hFE7, 8'h66);
    wr(12'hFD9, 8'hFF);
    wr(12'hFDA, 8'h0F);
    wr(12'h000, 8'h88);
    rd(12'hFDC, 8'h88);
    rd(12'hFDA, 8'h00);
    rd(12'hFDE, 8'h88);
    rd(12'hFD9, 8'h01);
  endtask : t_carry

  // Offset by the accumulator, pointer left alone
  task t_offset;
    wr(12'hFD9, 8'h00);
    wr(12'hFDA, 8'h02);
    wr(12'hFE8, 8'hFF);
    wr(12'h2FF, 8'h99);
    rd(12'hFDB, 8'h99);
    rd(12'hFD9, 8'h00);
    wr(12'hFDB, 8'h3C);
    rd(12'hFDB, 8'h3C);
    rd(12'h2FF, 8'h3C);
    wr(12'hFDF, 8'hC3);
    rd(12'hFDF, 8'hC3);
    rd(12'h200, 8'hC3);
  endtask : t_offset

  // Pointer one pre-step and offset, pointer zero offset,
  // pointer two post-decrement
  task t_more;
    wr(12'h101, 8'h5E);
    wr(12'hFE8, 8'h01);
    rd(12'hFE4, 8'h77);
    rd(12'hFE3, 8'h5E);
    rd(12'hFE1, 8'h00);
    wr(12'hFEB, 8'hE7);
    rd(12'hFEB, 8'hE7);
    rd(12'h137, 8'hE7);
    rd(12'hFE9, 8'h36);
    rd(12'hFDD, 8'hC3);
    rd(12'hFD9, 8'hFF);
    rd(12'hFDA, 8'h01);
  endtask : t_more

  // Reset in mid-run clears nonzero high bytes
  task t_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'hFEA, 8'h00);
    rd(12'hFDA, 8'h00);
  endtask : t_reset

  // Verdict and end of run
  task stop_test;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // Hang guard
  initial begin
    #200000;
    failures++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_high();
    t_plain();
    t_steps();
    t_carry();
    t_offset();
    t_more();
    t_reset();
    stop_test();
  end
endmodule : indirect_data_pointer_unit_tb_top
`default_nettype wire
